// ### hdl/timer16_consts.svh
`ifndef TIMER16_CONSTS_SVH
`define TIMER16_CONSTS_SVH

// counter and preload width
`define T16_WIDTH 16
// internal timer clock is the system clock divided by this ratio
`define T16_SYS_DIV 4
// prescale phase after which the divided clock falls
`define T16_DIV_LAST 2'h3
`define T16_DIV_RST 2'h0
// reset values
`define T16_COUNT_RST 16'h0000
`define T16_PRELOAD_RST 16'h0000
`define T16_RUN_RST 1'b0
`define T16_PFD_RST 1'b0

`endif

// ### hdl/timer16_pkg.sv
package timer16_pkg;

  typedef enum logic [1:0] {
    MODE_NONE    = 2'b00,
    MODE_EVENT   = 2'b01,
    MODE_TIMER   = 2'b10,
    MODE_CAPTURE = 2'b11
  } mode_type;

  typedef enum logic [1:0] {
    CAP_WAIT  = 2'b00,
    CAP_START = 2'b01,
    CAP_COUNT = 2'b10
  } cap_state_type;

endpackage : timer16_pkg

// ### hdl/edge_if.sv
interface edge_if;
  logic level;
  logic rise;
  logic fall;
  modport producer (output level, output rise, output fall);
  modport consumer (input level, input rise, input fall);
endinterface : edge_if

// ### hdl/edge_sync.sv
module edge_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // raw level
  input wire logic raw,
  // synchronised level and edge pulses
  edge_if.producer edges
);

  logic meta_r;
  logic sync_r;
  logic last_r;

  // meta_r feeds only sync_r; edges are taken from the settled stages
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign edges.level = sync_r;
  assign edges.rise = sync_r & ~last_r;
  assign edges.fall = ~sync_r & last_r;

endmodule : edge_sync

// ### hdl/timer16_event_capture_pfd.sv
// Overview of operation
// - mode bits 10 select timer mode
// - timer counts falling edges of fsys/4 or rc
// - overflow raises interrupt, reloads preload, keeps counting
// - overflow wakes; interrupt masked by enable bit
// - mode bits 01 select pin-clocked event counting
// - edge select low rising, high falling
// - counter runs only while run enable set
// - event counting continues during idle or sleep
// - mode bits 11 select capture, internal clock
// - capture waits idle for active pin edge
// - capture starts on active edge, stops on return
// - capture end clears run enable, single shot
// - other modes never clear run enable themselves
// - counter holds residual width; transitions, not levels
// - each overflow toggles divider output when selected
// - divider output low while gate bit zero
// - pull-high stays active while pin is input
// - mode 00 does nothing; 01,10,11 as listed
// - preload write when stopped also loads counter
// - event pin edges count at once; capture pin edges act at next timer clock
`include "timer16_consts.svh"

module timer16_event_capture_pfd
  import timer16_pkg::*;
#(
  parameter int WIDTH = `T16_WIDTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // control bits
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic clock_source_select,
  input wire logic active_edge_select,
  input wire logic pfd_select,
  input wire logic overflow_irq_enable,
  // run enable write port
  input wire logic run_enable_write,
  input wire logic run_enable_wdata,
  // preload write port
  input wire logic preload_write,
  input wire logic [WIDTH-1:0] preload_wdata,
  // pins and port configuration
  input wire logic low_speed_rc_clock,
  input wire logic external_count_input,
  input wire logic port_e_direction,
  input wire logic divider_output_gate,
  input wire logic pull_high_enable,
  // status and outputs
  output logic counter_run_enable,
  output logic [WIDTH-1:0] counter_value,
  output logic overflow_irq,
  output logic wake_up,
  output logic freq_divider_output,
  output logic pull_high_active
);

  localparam logic [WIDTH-1:0] ALL_ONES = '1;
  localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

  edge_if low_speed_rc_clock_edge ();
  edge_if pin_edge ();

  edge_sync u_low_speed_rc_clock_sync (
    .clock(clock),
    .rst_b(rst_b),
    .raw(low_speed_rc_clock),
    .edges(low_speed_rc_clock_edge.producer)
  );

  edge_sync u_pin_sync (
    .clock(clock),
    .rst_b(rst_b),
    .raw(external_count_input),
    .edges(pin_edge.producer)
  );

  mode_type mode;
  cap_state_type cap_state_r;
  logic [1:0] div_r;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] preload_r;
  logic run_r;
  logic stop_seen_r;
  logic toggle_r;
  logic irq_r;
  logic wake_r;
  logic pfd_out_r;
  logic pull_r;
  logic timer_tick;
  logic pin_ok;
  logic count_edge;
  logic start_edge;
  logic stop_edge;
  logic stop_now;
  logic cap_done;
  logic inc;
  logic ovf;

  assign mode = mode_type'({mode_select_hi, mode_select_lo});

  // free-running divide by four of the system clock
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      div_r <= `T16_DIV_RST;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end

  // tick marks the high-to-low transition of the chosen timer clock
  always_comb begin
    timer_tick = clock_source_select ? low_speed_rc_clock_edge.fall : (div_r == `T16_DIV_LAST);
  end

  // pin edges only count while the port treats the pin as an input
  always_comb begin
    pin_ok = port_e_direction;
    count_edge = pin_ok && (active_edge_select ? pin_edge.fall : pin_edge.rise);
    start_edge = pin_ok && (active_edge_select ? pin_edge.rise : pin_edge.fall);
    stop_edge = pin_ok && (active_edge_select ? pin_edge.fall : pin_edge.rise);
    stop_now = stop_seen_r || stop_edge;
  end

  // a stop edge takes effect at the next timer tick, so a short pulse still ends
  always_comb begin
    cap_done = run_r && (mode == MODE_CAPTURE) && (cap_state_r == CAP_COUNT)
               && timer_tick && stop_now;
  end

  always_comb begin
    inc = 1'b0;
    if (run_r) begin
      case (mode)
        MODE_TIMER: inc = timer_tick;
        MODE_EVENT: inc = count_edge;
        MODE_CAPTURE: begin
          inc = timer_tick && ((cap_state_r == CAP_START)
                || ((cap_state_r == CAP_COUNT) && !stop_now));
        end
        default: inc = 1'b0;
      endcase
    end
  end

  assign ovf = inc && (count_r == ALL_ONES);

  // capture sequencer, parked whenever the block is stopped or in another mode
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cap_state_r <= CAP_WAIT;
      stop_seen_r <= 1'b0;
    end else if (!run_r || (mode != MODE_CAPTURE)) begin
      cap_state_r <= CAP_WAIT;
      stop_seen_r <= 1'b0;
    end else begin
      case (cap_state_r)
        CAP_WAIT: begin
          if (start_edge) begin
            cap_state_r <= CAP_START;
          end
        end
        CAP_START: begin
          if (timer_tick) begin
            cap_state_r <= CAP_COUNT;
          end
          if (stop_edge) begin
            stop_seen_r <= 1'b1;
          end
        end
        CAP_COUNT: begin
          if (cap_done) begin
            cap_state_r <= CAP_WAIT;
            stop_seen_r <= 1'b0;
          end else if (stop_edge) begin
            stop_seen_r <= 1'b1;
          end
        end
        default: begin
          cap_state_r <= CAP_WAIT;
          stop_seen_r <= 1'b0;
        end
      endcase
    end
  end

  // a software write in the same cycle as the automatic clear wins
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      run_r <= `T16_RUN_RST;
    end else if (run_enable_write) begin
      run_r <= run_enable_wdata;
    end else if (cap_done) begin
      run_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      preload_r <= `T16_PRELOAD_RST;
    end else if (preload_write) begin
      preload_r <= preload_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      count_r <= `T16_COUNT_RST;
    end else if (preload_write && !run_r) begin
      count_r <= preload_wdata;
    end else if (ovf) begin
      count_r <= preload_r;
    end else if (inc) begin
      count_r <= count_r + ONE;
    end
  end

  // overflow events; wake-up is raised whatever the interrupt enable says
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= ovf && overflow_irq_enable;
      wake_r <= ovf;
    end
  end

  // divider output: toggled by overflow, gated by select and port data bit
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      toggle_r <= `T16_PFD_RST;
      pfd_out_r <= `T16_PFD_RST;
    end else begin
      toggle_r <= toggle_r ^ ovf;
      pfd_out_r <= pfd_select && divider_output_gate && toggle_r;
    end
  end

  // the pull-high follows its enable regardless of the pin's counter role
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pull_r <= 1'b0;
    end else begin
      pull_r <= pull_high_enable;
    end
  end

  assign counter_run_enable = run_r;
  assign counter_value = count_r;
  assign overflow_irq = irq_r;
  assign wake_up = wake_r;
  assign freq_divider_output = pfd_out_r;
  assign pull_high_active = pull_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence cap_stop_tick;
    cap_done && !run_enable_write;
  endsequence

  sequence cap_hold_3;
    (!run_enable_write && !preload_write && (mode == MODE_CAPTURE))[*3];
  endsequence

  AST_STOPPED_HOLDS: assert property (
    (!run_r && !preload_write) |=> $stable(count_r))
    else $error("counter moved while stopped");

  AST_TIMER_TICK: assert property (
    (run_r && mode == MODE_TIMER && timer_tick && count_r != ALL_ONES && !preload_write)
    |=> count_r == $past(count_r) + ONE)
    else $error("timer did not count on tick");

  AST_EVENT_EDGE: assert property (
    (run_r && mode == MODE_EVENT && !count_edge && !preload_write) |=> $stable(count_r))
    else $error("event counter moved without active edge");

  AST_OVF_RELOAD: assert property (
    ovf |=> (count_r == $past(preload_r)) && wake_up)
    else $error("overflow did not reload and wake");

  AST_IRQ_MASK: assert property (
    ovf |=> (overflow_irq == $past(overflow_irq_enable)))
    else $error("interrupt not gated by enable");

  AST_NO_AUTO_CLEAR: assert property (
    (run_r && mode != MODE_CAPTURE && !run_enable_write) |=> run_r)
    else $error("run enable cleared outside capture");

  AST_CAPTURE_WAIT: assert property (
    (run_r && mode == MODE_CAPTURE && cap_state_r == CAP_WAIT && !preload_write)
    |=> $stable(count_r))
    else $error("capture counted before start edge");

  AST_CAPTURE_ONESHOT: assert property (
    cap_stop_tick |=> !run_r ##0 cap_state_r == CAP_WAIT)
    else $error("capture end did not stop");

  AST_RESIDUAL_HOLDS: assert property (
    cap_stop_tick ##1 cap_hold_3 |-> $stable(count_r) && !run_r)
    else $error("residual value not held");

  AST_PRELOAD_STOPPED: assert property (
    (preload_write && !run_r) |=> count_r == $past(preload_wdata))
    else $error("stopped preload write not loaded");

  AST_PFD_TOGGLE: assert property (
    ovf |=> toggle_r != $past(toggle_r))
    else $error("overflow did not toggle divider");

  AST_PFD_GATE: assert property (
    !divider_output_gate |=> !freq_divider_output)
    else $error("divider output high while gated");

  AST_MODE_NONE: assert property (
    (mode == MODE_NONE && !preload_write) |=> $stable(count_r))
    else $error("counter moved with no mode");

endmodule : timer16_event_capture_pfd

// ### bench/pin_source.sv
module pin_source (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // pulse request
  input wire logic idle_level,
  input wire logic go,
  input wire logic [7:0] width,
  // counter pin
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_r;
  always_ff @(posedge clock) begin
    if (!rst_b)
      left_r <= 8'h00;
    else if (go)
      left_r <= width;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  // between pulses the pin rests at its idle level, set high or low by idle_level
  assign pin = (left_r != 8'h00) ? ~idle_level : idle_level;
endmodule : pin_source

// ### bench/test_timer16_event_capture_pfd.sv
module test_timer16_event_capture_pfd;
  timeunit 1ns;
  timeprecision 1ps;
  import timer16_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, hi = 1'b0, lo = 1'b0, src = 1'b0, es = 1'b0, pfd = 1'b0;
  logic irq_en = 1'b0, run_w = 1'b0, run_d = 1'b0, pre_w = 1'b0, rc = 1'b0, dir = 1'b1;
  logic gate = 1'b0, pull = 1'b0, idle = 1'b0, go = 1'b0, pin;
  logic [7:0] width = 8'h00;
  logic [15:0] pre_d = 16'h0000, p, q;
  logic run, irq, wake, fout, pull_act, f1;
  logic [15:0] value;
  int bad_count = 0, checks = 0, cycles = 0, n, k, w;

  timer16_event_capture_pfd timer16_event_capture_pfd_i (.clock(clock), .rst_b(rst_b),
    .mode_select_hi(hi), .mode_select_lo(lo), .clock_source_select(src),
    .active_edge_select(es), .pfd_select(pfd), .overflow_irq_enable(irq_en),
    .run_enable_write(run_w), .run_enable_wdata(run_d), .preload_write(pre_w),
    .preload_wdata(pre_d), .low_speed_rc_clock(rc), .external_count_input(pin),
    .port_e_direction(dir), .divider_output_gate(gate), .pull_high_enable(pull),
    .counter_run_enable(run), .counter_value(value), .overflow_irq(irq), .wake_up(wake),
    .freq_divider_output(fout), .pull_high_active(pull_act));
  pin_source pin_source_i (.clock(clock), .rst_b(rst_b), .idle_level(idle), .go(go),
    .width(width), .pin(pin));

  initial begin
    forever #12.5 clock = ~clock;
  end
  // slow rc source, free running, toggling every 400 ns on a falling edge of the system clock
  always #400 rc = ~rc;

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // cycles between overflows with the divide-by-four timer clock
  function automatic logic [15:0] period_cycles(input logic [15:0] pre);
    return 16'(4 * (65536 - int'(pre)));
  endfunction : period_cycles

  // capture may be a tick off either way: the pin is not aligned to the tick phase
  function automatic logic width_near(input logic [15:0] v, input int c);
    return (int'(v) >= c / 4 - 1) && (int'(v) <= c / 4 + 1);
  endfunction : width_near

  task complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      complete_run;
    end
  end

  task cyc(input int c);
    repeat (c) @(negedge clock);
  endtask : cyc

  task run_set(input logic v);
    @(negedge clock);
    run_w = 1'b1;
    run_d = v;
    @(negedge clock);
    run_w = 1'b0;
  endtask : run_set

  task preload(input logic [15:0] v);
    @(negedge clock);
    pre_w = 1'b1;
    pre_d = v;
    @(negedge clock);
    pre_w = 1'b0;
  endtask : preload

  task pulse(input logic lvl, input int wd);
    @(negedge clock);
    idle = lvl;
    width = wd[7:0];
    go = 1'b1;
    @(negedge clock);
    go = 1'b0;
  endtask : pulse

  task wait_wake;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (wake !== 1'b1 && n < 3000);
  endtask : wait_wake

  initial begin
    void'($urandom(32'hEF5EF5E9));
    cyc(4);
    rst_b = 1'b1;
    check(value, 16'h0000);
    check({15'h0000, run}, 16'h0000);
    pull = 1'b1;
    cyc(2);
    check({15'h0000, pull_act}, 16'h0001);
    p = 16'($urandom);
    preload(p);
    check(value, p);
    run_set(1'b1);
    cyc(40);
    check(value, p);
    run_set(1'b0);
    $display("test reset and idle mode done");

    {hi, lo} = 2'b10;
    irq_en = 1'b1;
    pfd = 1'b1;
    gate = 1'b1;
    p = 16'hFFE0 + 16'($urandom % 16);
    preload(p);
    run_set(1'b1);
    wait_wake;
    check(value, p);
    check({15'h0000, wake}, 16'h0001);
    check({15'h0000, irq}, 16'h0001);
    wait_wake;
    check(16'(n), period_cycles(p));
    q = p + 16'h0001;
    preload(q);
    wait_wake;
    check(value, q);
    irq_en = 1'b0;
    wait_wake;
    check({15'h0000, irq}, 16'h0000);
    check({15'h0000, wake}, 16'h0001);
    check({15'h0000, run}, 16'h0001);
    cyc(2);
    f1 = fout;
    wait_wake;
    cyc(2);
    check({15'h0000, fout}, {15'h0000, ~f1});
    gate = 1'b0;
    cyc(2);
    check({15'h0000, fout}, 16'h0000);
    src = 1'b1;
    wait_wake;
    check(value, q);
    src = 1'b0;
    run_set(1'b0);
    $display("test timer done");

    for (int e = 0; e < 2; e++) begin
      {hi, lo} = 2'b01;
      es = e[0];
      dir = 1'b1;
      p = 16'($urandom % 4096);
      preload(p);
      run_set(1'b1);
      pulse(1'b0, 20);
      cyc(10);
      check(value, p + 16'(1 - e));
      cyc(20);
      check(value, p + 16'h0001);
      k = 1 + $urandom % 5;
      repeat (k) begin
        pulse(1'b0, 4 + $urandom % 8);
        cyc(16);
      end
      check(value, p + 16'(1 + k));
      dir = 1'b0;
      pulse(1'b0, 6);
      cyc(16);
      check(value, p + 16'(1 + k));
      dir = 1'b1;
      run_set(1'b0);
    end
    // overflow on a pin edge reloads and wakes just as in timer mode
    preload(16'hFFFF);
    run_set(1'b1);
    pulse(1'b0, 4);
    wait_wake;
    check(value, 16'hFFFF);
    check({15'h0000, wake}, 16'h0001);
    run_set(1'b0);
    $display("test event counter done");

    for (int e = 0; e < 2; e++) begin
      {hi, lo} = 2'b11;
      es = e[0];
      idle = ~es;
      preload(16'h0000);
      run_set(1'b1);
      cyc(20);
      check(value, 16'h0000);
      w = 40 + $urandom % 40;
      pulse(~es, w);
      n = 0;
      while (run !== 1'b0 && n < 400) begin
        @(negedge clock);
        n++;
      end
      check({15'h0000, run}, 16'h0000);
      check({15'h0000, width_near(value, w)}, 16'h0001);
      p = value;
      pulse(~es, w);
      cyc(w + 20);
      check(value, p);
    end
    $display("test capture done");
    complete_run;
  end
endmodule : test_timer16_event_capture_pfd
